//--- hdl/sltim_pkg.sv
// constants, enums and carrier structs of the servo loop test injection monitor
package sltim_pkg;

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int MAX_LOOP_HZ = 32_000;
  localparam int SHARED_LOOP_HZ = 16_000;
  // shortest loop period, rounded up to whole clocks
  localparam logic [15:0] MIN_PERIOD = 16'((CLK_HZ + MAX_LOOP_HZ - 1) / MAX_LOOP_HZ);
  // shortest period at which anti-alias and monitor may share the loop
  localparam logic [15:0] SHARED_PERIOD =
    16'((CLK_HZ + SHARED_LOOP_HZ - 1) / SHARED_LOOP_HZ);
  localparam logic [15:0] PERIOD_ONE = 16'h0001;

  localparam int NUM_AXES = 2;

  // sample format: signed, 1 V = 1 A = 1 position unit = VOLT_CODE codes
  typedef logic signed [15:0] sltim_sample_t;
  localparam sltim_sample_t VOLT_CODE = 16'sh0ccd;
  localparam sltim_sample_t SAMPLE_ZERO = 16'sh0000;
  // dac full scale is +10 V / -10 V, symmetric
  localparam sltim_sample_t DAC_POS_FULL = 16'sh7fff;
  localparam sltim_sample_t DAC_NEG_FULL = 16'sh8001;
  // scales are signed 8.8 fixed point
  localparam int SCALE_FRAC = 8;
  localparam sltim_sample_t SCALE_UNITY = 16'sh0100;

  // register byte offsets
  localparam logic [7:0] REG_PERIOD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG0 = 8'h08;
  localparam logic [7:0] REG_SCALE0 = 8'h0c;
  localparam logic [7:0] AXIS_STRIDE = 8'h08;
  // status fields
  localparam int ST_ERR_BIT = 0;
  localparam int ST_ACT_LSB = 1;

  typedef enum logic [1:0] {
    inject_off = 2'h0,
    inject_at_position = 2'h1,
    inject_at_ctrl_output = 2'h2
  } sltim_inject_e;

  typedef enum logic [2:0] {
    monitor_off = 3'h0,
    monitor_ctrl_output = 3'h1,
    monitor_ctrl_plus_test = 3'h2,
    monitor_relative_position = 3'h3,
    monitor_following_error = 3'h4,
    monitor_setpoint_position = 3'h5
  } sltim_monitor_e;

  // axis configuration word, bits 6:0
  typedef struct packed {
    logic anti_alias_function;
    logic ext_drive;
    sltim_monitor_e monitor_point_select;
    sltim_inject_e inject_point_select;
  } sltim_cfg_s;
  localparam sltim_cfg_s CFG_RESET = '{1'b0, 1'b0, monitor_off, inject_off};

  // scale word: monitor scale in 31:16, inject scale in 15:0
  typedef struct packed {
    sltim_sample_t monitor_scale;
    sltim_sample_t inject_scale;
  } sltim_scale_s;
  localparam sltim_scale_s SCALE_RESET = '{SCALE_UNITY, SCALE_UNITY};

  // loop signals handed in by the position loop unit each sample
  typedef struct packed {
    sltim_sample_t ctrl_output_tap;
    sltim_sample_t position_tap;
    sltim_sample_t following_error_tap;
    sltim_sample_t setpoint_position_tap;
  } sltim_tap_s;

  // test values handed to the position loop unit
  typedef struct packed {
    sltim_sample_t position_inject_point;
    sltim_sample_t ctrl_inject_point;
  } sltim_inject_s;

endpackage : sltim_pkg

//--- hdl/sltim_top.sv
// servo loop test injection and analog monitor path for two axes
`timescale 1ns/1ps
//
// Overview of operation
// - Inject selector off injects nothing; off is the reset setting.
// - Position selection adds scaled analog input to the position path.
// - Controller selection adds scaled analog input to the controller output.
// - One injection point at a time; the unused point stays zero.
// - Input is multiplied by inject scale; unity makes 1 V one position unit.
// - At unity inject scale 1 V at controller point is 1 A.
// - Monitor selector off writes the DAC only on external drive axes; off is the reset setting.
// - Five monitor points plus off are selectable.
// - Controller monitor outputs controller output without the test signal.
// - Controller-plus-test monitor outputs controller output plus controller injection.
// - Position monitor captures position once, then outputs position minus it.
// - Following error monitor outputs the loop position error each sample.
// - Monitor value times monitor scale; unity maps 1 A to 1 V.
// - At unity monitor scale position monitors map one unit to 1 V.
// - Scaled values beyond DAC range saturate at full scale, never wrap.
// - Inputs sampled and output updated once per configurable loop period.
// - Input to DAC latency is at least one loop period.
// - Analog output n belongs to axis n, fixed.
// - Monitor drives the output only when no other use claims it.
// - External drive axes output unscaled controller-plus-test whenever their output is not claimed.
// - Anti-alias and monitor together only at or below 16 kHz, else error.
module sltim_top
  import sltim_pkg::*;
(
  input wire logic sys_clk, // 20 MHz system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte enables
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire sltim_sample_t [NUM_AXES-1:0] adc_code, // digitized analog inputs
  input wire sltim_tap_s [NUM_AXES-1:0] loop_taps, // loop signals per axis
  input wire logic [NUM_AXES-1:0] aout_claimed, // output used by another monitor
  output sltim_inject_s [NUM_AXES-1:0] inject, // test values into the loop
  output sltim_sample_t [NUM_AXES-1:0] dac_code, // analog output codes
  output logic [NUM_AXES-1:0] dac_write, // dac write pulse
  output logic sample_tick // loop sample boundary pulse
);

  // multiply by an 8.8 scale; wide enough that nothing wraps before saturation
  function automatic logic signed [31:0] scale_by(
    input logic signed [31:0] value,
    input sltim_sample_t factor
  );
    logic signed [47:0] product;
    product = value * factor;
    return 32'(product >>> SCALE_FRAC);
  endfunction : scale_by

  // clip to the symmetric dac range
  function automatic sltim_sample_t clip(input logic signed [31:0] value);
    sltim_sample_t res;
    res = value[15:0];
    if (value > 32'(DAC_POS_FULL)) begin
      res = DAC_POS_FULL;
    end else if (value < 32'(DAC_NEG_FULL)) begin
      res = DAC_NEG_FULL;
    end
    return res;
  endfunction : clip

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // the monitor path counts as active when either selector is on
  function automatic logic monitor_active(input sltim_cfg_s cfg);
    return (cfg.inject_point_select != inject_off) ||
           (cfg.monitor_point_select != monitor_off);
  endfunction : monitor_active

  // anti-alias and monitor both active
  function automatic logic both_on(input sltim_cfg_s cfg);
    return cfg.anti_alias_function && monitor_active(cfg);
  endfunction : both_on

  // ---- loop sample divider
  logic [15:0] loop_period;
  logic [15:0] period_cnt;
  wire tick = (period_cnt >= loop_period - PERIOD_ONE);

  // free-running divider; every slower action is gated by tick
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      period_cnt <= 16'h0000;
      sample_tick <= 1'b0;
    end else begin
      period_cnt <= tick ? 16'h0000 : period_cnt + PERIOD_ONE;
      sample_tick <= tick;
    end
  end

  // ---- wishbone decode
  sltim_cfg_s [NUM_AXES-1:0] sw_cfg;
  sltim_scale_s [NUM_AXES-1:0] sw_scale;
  sltim_cfg_s [NUM_AXES-1:0] act_cfg;
  logic err_flag;

  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_req && wb_we_i;
  wire hit_period = (wb_adr_i == REG_PERIOD);
  wire hit_status = (wb_adr_i == REG_STATUS);
  logic [NUM_AXES-1:0] hit_cfg;
  logic [NUM_AXES-1:0] hit_scale;
  logic [NUM_AXES-1:0] cfg_conflict;
  logic [NUM_AXES-1:0] any_both;
  logic [NUM_AXES-1:0] act_on;

  // proposed period, never below the fastest loop rate
  wire [31:0] period_merged = merge({16'h0000, loop_period}, wb_dat_i, wb_sel_i);
  wire [15:0] period_new =
    (period_merged[15:0] < MIN_PERIOD) ? MIN_PERIOD : period_merged[15:0];
  wire period_fast = (period_new < SHARED_PERIOD);
  wire now_fast = (loop_period < SHARED_PERIOD);

  // a faster period is refused while any axis runs both functions
  wire period_refused = wb_wr && hit_period && period_fast && (|any_both);
  wire cfg_refused = wb_wr && (|cfg_conflict);
  wire err_set = period_refused || cfg_refused;
  wire err_clr = wb_wr && hit_status && wb_sel_i[0] && wb_dat_i[ST_ERR_BIT];

  // period register and sticky conflict flag; a new conflict beats a clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_period <= MIN_PERIOD;
      err_flag <= 1'b0;
    end else begin
      if (wb_wr && hit_period && !period_refused) begin
        loop_period <= period_new;
      end
      err_flag <= err_set || (err_flag && !err_clr);
    end
  end

  // ---- per-axis path; axis n always drives analog output n
  genvar a;
  generate
    for (a = 0; a < NUM_AXES; a++) begin : g_axis
      localparam logic [7:0] CFG_ADR = 8'(REG_CFG0 + a * AXIS_STRIDE);
      localparam logic [7:0] SCALE_ADR = 8'(REG_SCALE0 + a * AXIS_STRIDE);

      assign hit_cfg[a] = (wb_adr_i == CFG_ADR);
      assign hit_scale[a] = (wb_adr_i == SCALE_ADR);
      assign any_both[a] = both_on(sw_cfg[a]);
      assign act_on[a] = monitor_active(act_cfg[a]);

      // proposed configuration and its conflict check
      wire [31:0] cfg_merged = merge(32'(sw_cfg[a]), wb_dat_i, wb_sel_i);
      wire sltim_cfg_s cfg_new = sltim_cfg_s'(cfg_merged[$bits(sltim_cfg_s)-1:0]);
      assign cfg_conflict[a] = hit_cfg[a] && now_fast && both_on(cfg_new);
      wire [31:0] scale_new = merge(sw_scale[a], wb_dat_i, wb_sel_i);

      // software copies; they reach the loop only at the next tick
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          sw_cfg[a] <= CFG_RESET;
          sw_scale[a] <= SCALE_RESET;
        end else begin
          if (wb_wr && hit_cfg[a] && !cfg_refused) begin
            sw_cfg[a] <= cfg_new;
          end
          if (wb_wr && hit_scale[a]) begin
            sw_scale[a] <= scale_new;
          end
        end
      end

      // settings in force for this sample, all taken together
      wire sltim_cfg_s cfg = sw_cfg[a];
      wire sltim_scale_s scl = sw_scale[a];
      wire sltim_tap_s taps = loop_taps[a];

      // scaled test value; one volt stands for one unit at unity scale
      wire sltim_sample_t test_val =
        clip(scale_by(32'(adc_code[a]), scl.inject_scale));
      wire sltim_sample_t pos_inj =
        (cfg.inject_point_select == inject_at_position) ? test_val : SAMPLE_ZERO;
      // the controller point stays zero unless it is selected
      wire ctrl_sel = (cfg.inject_point_select == inject_at_ctrl_output);
      wire sltim_sample_t ctrl_inj = ctrl_sel ? test_val : SAMPLE_ZERO;

      // position offset is caught on entry into the position monitor
      sltim_sample_t pos_offset;
      wire entering_pos =
        (cfg.monitor_point_select == monitor_relative_position) &&
        (act_cfg[a].monitor_point_select != monitor_relative_position);
      wire sltim_sample_t offset_now = entering_pos ? taps.position_tap : pos_offset;

      // monitor taps, kept wide so sums cannot wrap
      wire signed [31:0] ctrl_plus_test =
        32'(taps.ctrl_output_tap) + 32'(ctrl_inj);
      wire signed [31:0] rel_pos = 32'(taps.position_tap) - 32'(offset_now);
      logic signed [31:0] tap_sel;
      always_comb begin
        unique case (cfg.monitor_point_select)
          monitor_ctrl_output: tap_sel = 32'(taps.ctrl_output_tap);
          monitor_ctrl_plus_test: tap_sel = ctrl_plus_test;
          monitor_relative_position: tap_sel = rel_pos;
          monitor_following_error: tap_sel = 32'(taps.following_error_tap);
          monitor_setpoint_position: tap_sel = 32'(taps.setpoint_position_tap);
          default: tap_sel = 32'sh0000_0000; // off and unused codes
        endcase
      end

      // external drive overrides the selector and skips the monitor scale
      wire signed [31:0] stage_in =
        cfg.ext_drive ? ctrl_plus_test : tap_sel;
      wire sltim_sample_t stage_scale_in =
        cfg.ext_drive ? SCALE_UNITY : scl.monitor_scale;
      // write only when selected or externally driven and the output is not used elsewhere
      wire stage_wr_in = !aout_claimed[a] &&
        (cfg.ext_drive || (cfg.monitor_point_select != monitor_off));

      // one sample of pipeline between the loop and the dac
      logic signed [31:0] stage_val;
      sltim_sample_t stage_scale;
      logic stage_wr;

      // everything below moves only on the sample boundary
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          act_cfg[a] <= CFG_RESET;
          pos_offset <= SAMPLE_ZERO;
          inject[a] <= '0;
          stage_val <= 32'sh0000_0000;
          stage_scale <= SCALE_UNITY;
          stage_wr <= 1'b0;
          dac_code[a] <= SAMPLE_ZERO;
        end else if (tick) begin
          act_cfg[a] <= cfg;
          pos_offset <= offset_now;
          inject[a] <= '{pos_inj, ctrl_inj};
          stage_val <= stage_in;
          stage_scale <= stage_scale_in;
          stage_wr <= stage_wr_in;
          // previous sample reaches the dac now, a full period later
          if (stage_wr) begin
            dac_code[a] <= clip(scale_by(stage_val, stage_scale));
          end
        end
      end

      // one-cycle write pulse at the tick that updates the code
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          dac_write[a] <= 1'b0;
        end else begin
          dac_write[a] <= tick && stage_wr;
        end
      end
    end
  endgenerate

  // ---- read mux
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000; // unmapped addresses read zero
    if (hit_period) begin
      rd_data = {16'h0000, loop_period};
    end else if (hit_status) begin
      rd_data[ST_ERR_BIT] = err_flag;
      rd_data[ST_ACT_LSB +: NUM_AXES] = act_on;
    end
    for (int i = 0; i < NUM_AXES; i++) begin
      if (hit_cfg[i]) begin
        rd_data = 32'(sw_cfg[i]);
      end
      if (hit_scale[i]) begin
        rd_data = sw_scale[i];
      end
    end
  end

  // single-wait acknowledge; every address is answered
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule : sltim_top

//--- tb/sltim_monitor.sv
// assertion checker for the servo loop test injection and monitor block
`timescale 1ns/1ps
module sltim_monitor
  import sltim_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic reset_n, // async reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [7:0] wb_adr_i, // bus address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire sltim_sample_t [NUM_AXES-1:0] adc_code, // adc codes
  input wire sltim_tap_s [NUM_AXES-1:0] loop_taps, // loop taps
  input wire logic [NUM_AXES-1:0] aout_claimed, // output claims
  input wire sltim_inject_s [NUM_AXES-1:0] inject, // test values
  input wire sltim_sample_t [NUM_AXES-1:0] dac_code, // dac codes
  input wire logic [NUM_AXES-1:0] dac_write, // dac pulses
  input wire logic sample_tick // boundary pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // clocks since the last boundary; saturates so a stalled divider cannot wrap
  logic [15:0] gap_cnt;
  logic [15:0] next_gap_cnt;
  assign next_gap_cnt = sample_tick ? 16'h0001 : (&gap_cnt ? gap_cnt : gap_cnt + 16'h0001);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) gap_cnt <= 16'h0000;
    else gap_cnt <= next_gap_cnt;
  end
  // bus handshake steps
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next: assert property (s_bus_req |=> s_ack_pulse)
    else $error("ack not a single pulse one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_tick_gap: assert property (sample_tick |-> gap_cnt >= MIN_PERIOD)
    else $error("loop boundaries closer than shortest period");
  a_write_on_tick: assert property (dac_write != 2'h0 |-> sample_tick)
    else $error("dac written off a loop boundary");
  a_dac_hold: assert property (!sample_tick |-> $stable(dac_code))
    else $error("dac code moved between boundaries");
  a_dac_written: assert property ($changed(dac_code[0]) |-> dac_write[0])
    else $error("dac code changed without write pulse");
  a_inject_hold: assert property (!sample_tick |-> $stable(inject))
    else $error("injection moved between boundaries");
  a_one_point: assert property (inject[0].position_inject_point != SAMPLE_ZERO
    |-> inject[0].ctrl_inject_point == SAMPLE_ZERO)
    else $error("both injection points active");
  a_no_wrap: assert property (dac_write[0] |-> dac_code[0] != 16'sh8000)
    else $error("dac code outside symmetric range");
endmodule : sltim_monitor

bind sltim_top sltim_monitor i_mon (.sys_clk(sys_clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .adc_code(adc_code), .loop_taps(loop_taps), .aout_claimed(aout_claimed), .inject(inject),
  .dac_code(dac_code), .dac_write(dac_write), .sample_tick(sample_tick));

//--- tb/sltim_sig_gen.sv
// sample-and-hold signal generator feeding the digitized analog inputs
`timescale 1ns/1ps
module sltim_sig_gen
  import sltim_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic reset_n, // async reset
  input wire logic sample_tick, // loop boundary pulse
  input wire sltim_sample_t [NUM_AXES-1:0] gen_level, // wanted level
  output sltim_sample_t [NUM_AXES-1:0] adc_code // held codes
);
  logic tick_d;
  // relatch one clock after a boundary so the code is steady over the next sampling edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_d <= 1'b0;
      adc_code <= '0;
    end else begin
      tick_d <= sample_tick;
      if (tick_d) adc_code <= gen_level;
    end
  end
endmodule : sltim_sig_gen

//--- tb/testbench.sv
// self-checking bench for the servo loop test injection and monitor block
`timescale 1ns/1ps
module testbench import sltim_pkg::*;;
  localparam int NSC = 11;
  typedef struct packed {logic [1:0][1:0] kind; sltim_sample_t [1:0] val;} sltim_note_s;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, sample_tick;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  sltim_sample_t [1:0] adc_code, dac_code, gen_level = '0;
  sltim_tap_s [1:0] loop_taps = '0;
  logic [1:0] aout_claimed = 2'h0, dac_write;
  sltim_inject_s [1:0] inject;
  int mismatches = 0, num_checks = 0;
  logic [15:0] seed = 16'h001c;
  logic [63:0] inj_q[$];
  sltim_note_s dac_q[$];
  logic [31:0] rd_q[$];
  sltim_sample_t off_v[2];
  // case table: config word, monitor scale, inject scale; case 8 has its output claimed
  logic [6:0] t_cfg[NSC] = '{7'h00, 7'h09, 7'h06, 7'h0a, 7'h0d, 7'h11, 7'h16, 7'h06, 7'h04,
    7'h22, 7'h18};
  sltim_sample_t t_ms[NSC] = '{16'sh0100, 16'sh0100, 16'sh0100, 16'sh0100, 16'sh0100,
    16'sh0100, 16'sh0200, 16'sh4000, 16'sh0100, 16'sh0400, 16'sh0100};
  sltim_sample_t t_is[NSC] = '{16'sh0100, 16'sh0100, 16'sh0100, 16'sh0080, 16'sh0100,
    16'sh0100, 16'sh0100, 16'sh0200, 16'sh0100, 16'sh0100, 16'sh0100};

  initial forever #25 sys_clk = ~sys_clk;

  sltim_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_code(adc_code),
    .loop_taps(loop_taps), .aout_claimed(aout_claimed), .inject(inject),
    .dac_code(dac_code), .dac_write(dac_write), .sample_tick(sample_tick));
  sltim_sig_gen i_gen (.sys_clk(sys_clk), .reset_n(reset_n), .sample_tick(sample_tick),
    .gen_level(gen_level), .adc_code(adc_code));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // expected scaling: floor shift, then symmetric saturation instead of wrap
  function automatic sltim_sample_t sat_scale(input logic signed [31:0] v, input sltim_sample_t s);
    logic signed [47:0] p;
    p = (v * s) >>> SCALE_FRAC;
    if (p > 48'sd32767) return DAC_POS_FULL;
    if (p < -48'sd32767) return DAC_NEG_FULL;
    return p[15:0];
  endfunction : sat_scale
  // small random codes keep sums inside 16 bits, so only the scaling can saturate
  task automatic rnd(output sltim_sample_t r);
    seed = lfsr_next(seed);
    r = {{3{seed[12]}}, seed[12:0]};
  endtask : rnd
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // one classic bus cycle; a read notes its expected data for the watcher
  task automatic wb_op(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    if (!we) rd_q.push_back(d);
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_op
  task automatic next_tick;
    do @(posedge sys_clk); while (sample_tick !== 1'b1);
  endtask : next_tick
  // three periods per case: settle, checked sample, then one spanning the next change
  task automatic run_case(input int i);
    int e;
    sltim_cfg_s c;
    sltim_tap_s tp;
    sltim_sample_t ad, pi, ci, v;
    sltim_note_s dn;
    sltim_inject_s [1:0] ie;
    for (int r = 0; r < 3; r++) begin
      next_tick();
      for (int a = 0; a < 2; a++) begin
        e = (i + 3 * a) % NSC;
        c = sltim_cfg_s'(t_cfg[e]);
        rnd(ad);
        rnd(tp.ctrl_output_tap);
        rnd(tp.position_tap);
        rnd(tp.following_error_tap);
        rnd(tp.setpoint_position_tap);
        gen_level[a] <= ad;
        loop_taps[a] <= tp;
        aout_claimed[a] <= (e == 8);
        pi = sat_scale(ad, t_is[e]);
        ci = (c.inject_point_select == inject_at_ctrl_output) ? pi : SAMPLE_ZERO;
        ie[a].position_inject_point =
          (c.inject_point_select == inject_at_position) ? pi : SAMPLE_ZERO;
        ie[a].ctrl_inject_point = ci;
        if (r == 0) off_v[a] = tp.position_tap;
        // unused selector codes still write, with a zero value
        case (c.monitor_point_select)
          monitor_ctrl_output: v = tp.ctrl_output_tap;
          monitor_ctrl_plus_test: v = tp.ctrl_output_tap + ci;
          monitor_relative_position: v = tp.position_tap - off_v[a];
          monitor_following_error: v = tp.following_error_tap;
          monitor_setpoint_position: v = tp.setpoint_position_tap;
          default: v = SAMPLE_ZERO;
        endcase
        dn.val[a] = c.ext_drive ? sat_scale(tp.ctrl_output_tap + ci, SCALE_UNITY)
          : sat_scale(v, t_ms[e]);
        dn.kind[a] = (r != 1) ? 2'h2 :
          ((e == 8) || !(c.ext_drive || c.monitor_point_select != monitor_off)) ? 2'h0 : 2'h1;
      end
      inj_q.push_back(ie);
      dac_q.push_back(dn);
      for (int a = 0; a < 2 && r == 0; a++) begin
        e = (i + 3 * a) % NSC;
        wb_op(1'b1, 8'(REG_CFG0 + AXIS_STRIDE * a), 32'(t_cfg[e]));
        wb_op(1'b1, 8'(REG_SCALE0 + AXIS_STRIDE * a), {t_ms[e], t_is[e]});
      end
    end
  endtask : run_case

  // watcher: at every boundary and read acknowledge take the oldest note and compare
  always @(negedge sys_clk) begin : watch
    sltim_note_s dn;
    if (sample_tick === 1'b1 && dac_q.size() > 0) begin
      if (inj_q.size() > 0) check("inject", inject, inj_q.pop_front());
      dn = dac_q.pop_front();
      for (int a = 0; a < 2; a++) begin
        if (dn.kind[a] < 2'h2) check("dac_write", dac_write[a], dn.kind[a][0]);
        if (dn.kind[a] == 2'h1) check("dac_code", dac_code[a], dn.val[a]);
      end
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
      check("wb_dat_o", wb_dat_o, rd_q.pop_front());
  end

  // watchdog: 35 periods of 625 clocks plus margin
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    inj_q.push_back('0);
    dac_q.push_back('0);
    dac_q.push_back('0);
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    wb_op(1'b0, REG_PERIOD, 32'h0000_0271);
    wb_op(1'b0, REG_CFG0, 32'h0000_0000);
    wb_op(1'b0, REG_SCALE0, 32'h0100_0100);
    wb_op(1'b0, 8'h40, 32'h0000_0000);
    // a single byte lane merges into the stored period
    wb_op(1'b1, REG_PERIOD, 32'h0000_0500, 4'h2);
    wb_op(1'b0, REG_PERIOD, 32'h0000_0571);
    wb_op(1'b1, REG_PERIOD, 32'h0000_0010);
    wb_op(1'b0, REG_PERIOD, 32'h0000_0271);
    wb_op(1'b1, REG_CFG0, 32'h0000_0044);
    wb_op(1'b0, REG_STATUS, 32'h0000_0001);
    wb_op(1'b0, REG_CFG0, 32'h0000_0000);
    wb_op(1'b1, REG_STATUS, 32'h0000_0001);
    wb_op(1'b0, REG_STATUS, 32'h0000_0000);
    for (int i = 0; i < NSC; i++) run_case(i);
    repeat (2) next_tick();
    give_verdict();
  end
endmodule : testbench
